// [hw/rsse_consts.svh]
// constants for the rotate / sleep / literal-subtract execution block
`ifndef RSSE_CONSTS_SVH
`define RSSE_CONSTS_SVH
`define RSSE_DATA_W      8
`define RSSE_ADDR_W      7
`define RSSE_FILE_MAX    7'h7f
`define RSSE_WDT_W       8
`define RSSE_PRE_W       8
`define RSSE_WDT_CLR     8'h00
`define RSSE_PRE_CLR     8'h00
`define RSSE_ACC_RST     8'h00
`define RSSE_NIB_HI      3
`define RSSE_MSB         7
`define RSSE_DEST_ACC    1'b0
`define RSSE_DEST_FILE   1'b1
`endif

// [hw/rsse_pkg.sv]
// types for the rotate / sleep / literal-subtract execution block
package rsse_pkg;
    typedef enum logic [2:0] {
        RSSE_OP_NONE,
        RSSE_OP_ROT_LEFT,
        RSSE_OP_ROT_RIGHT,
        RSSE_OP_SUB_LIT,
        RSSE_OP_SLEEP
    } rsse_op_t;
    typedef enum logic {
        RSSE_RUN,
        RSSE_ASLEEP
    } rsse_pwr_t;
endpackage : rsse_pkg

// [hw/rsse_alu.sv]
// combinational rotate-through-carry and literal-minus-accumulator arithmetic
`timescale 1ns/1ps
`include "rsse_consts.svh"
module rsse_alu #(
    parameter int W = `RSSE_DATA_W
) (
    input  wire rsse_pkg::rsse_op_t op,         // operation to evaluate
    input  wire logic [W-1:0]       file_val,   // addressed file register value
    input  wire logic [W-1:0]       accum,      // accumulator value
    input  wire logic [W-1:0]       literal,    // instruction literal
    input  wire logic               carry_in,   // current carry flag
    output logic [W-1:0]            result,     // computed result
    output logic                    carry_out,  // new carry
    output logic                    half_out,   // new half borrow flag
    output logic                    zero_out    // result is zero
);
    import rsse_pkg::*;
    logic [W:0] diff;
    logic [4:0] ndiff;
    // two's complement subtract; the extra bit is the inverted borrow
    always_comb begin
        diff  = {1'b0, literal} + {1'b0, ~accum} + {{W{1'b0}}, 1'b1};
        ndiff = {1'b0, literal[3:0]} + {1'b0, ~accum[3:0]} + 5'h01;
        result    = file_val;
        carry_out = carry_in;
        half_out  = 1'b0;
        case (op)
            RSSE_OP_ROT_LEFT: begin
                result    = {file_val[W-2:0], carry_in};
                carry_out = file_val[W-1];
            end
            RSSE_OP_ROT_RIGHT: begin
                result    = {carry_in, file_val[W-1:1]};
                carry_out = file_val[0];
            end
            RSSE_OP_SUB_LIT: begin
                result    = diff[W-1:0];
                carry_out = diff[W];                                    // set when accum <= literal
                half_out  = ndiff[4];
            end
            default: begin
                result = file_val;
            end
        endcase
        zero_out = (result == '0);
    end
endmodule : rsse_alu

// [hw/rsse_exec.sv]
// execution unit for rotate, literal subtract and sleep instructions
// Operation
// - rotate left moves the file register up one bit, old carry into bit 0, bit 7 to carry.
// - rotate left writes the accumulator when the destination is 0, the file when it is 1.
// - rotate right moves the file register down one bit, old carry into bit 7, bit 0 to carry.
// - rotate right writes the accumulator when the destination is 0, the file when it is 1.
// - sleep clears the power-down flag, sets the time-out flag and keeps other flags.
// - sleep clears the watchdog counter to 00h and its prescaler to zero.
// - after sleep the core stops its oscillator and halts until woken.
// - literal subtract puts literal minus accumulator into the accumulator.
// - literal subtract sets carry when accum <= literal and half borrow on the low nibble.
`timescale 1ns/1ps
`include "rsse_consts.svh"
module rsse_exec #(
    parameter int DATA_W = `RSSE_DATA_W,
    parameter int ADDR_W = `RSSE_ADDR_W
) (
    input  wire logic               mclk,          // core clock, 125 MHz
    input  wire logic               rst,           // synchronous reset, active high
    input  wire logic               instr_valid,   // decoded instruction present
    input  wire rsse_pkg::rsse_op_t instr_op,      // decoded operation
    input  wire logic [ADDR_W-1:0]  file_addr,     // file register address
    input  wire logic               dest_sel,      // 0 accumulator, 1 file register
    input  wire logic [DATA_W-1:0]  literal,       // 8-bit literal
    input  wire logic [DATA_W-1:0]  file_rdata,    // addressed file register contents
    input  wire logic               wake,          // wake-up event from sleep
    output logic                    file_we,       // file register write strobe
    output logic [ADDR_W-1:0]       file_waddr,    // file register write address
    output logic [DATA_W-1:0]       file_wdata,    // file register write data
    output logic [DATA_W-1:0]       accum,         // accumulator
    output logic                    carry_flag,    // carry flag
    output logic                    half_borrow_flag, // half borrow flag
    output logic                    zero_flag,     // zero flag
    output logic                    power_down_flag,  // power-down status, low after sleep
    output logic                    time_out_flag, // time-out status
    output logic                    wdt_clear,     // clears watchdog_counter and prescaler
    output logic                    osc_run,       // oscillator enable
    output logic                    exec_halted    // instruction execution stopped
);
    import rsse_pkg::*;

    logic [DATA_W-1:0] alu_res;
    logic              alu_c, alu_hb, alu_z;
    logic              act;

    logic [DATA_W-1:0] accum_r, accum_nxt;
    logic              c_r, c_nxt, hb_r, hb_nxt, z_r, z_nxt;
    logic              pwd_r, pwd_nxt, to_r, to_nxt;
    logic              we_r, we_nxt, wclr_r, wclr_nxt;
    logic [ADDR_W-1:0] waddr_r, waddr_nxt;
    logic [DATA_W-1:0] wdata_r, wdata_nxt;
    rsse_pwr_t         pwr_r, pwr_nxt;

    rsse_alu #(.W(DATA_W)) u_alu (
        .op        (instr_op),
        .file_val  (file_rdata),
        .accum     (accum_r),
        .literal   (literal),
        .carry_in  (c_r),
        .result    (alu_res),
        .carry_out (alu_c),
        .half_out  (alu_hb),
        .zero_out  (alu_z)
    );

    // instructions are ignored while asleep; nothing queues behind sleep
    assign act = instr_valid && (pwr_r == RSSE_RUN);

    // next state: every instruction retires in the cycle it is presented
    always_comb begin
        accum_nxt = accum_r;
        c_nxt     = c_r;
        hb_nxt    = hb_r;
        z_nxt     = z_r;
        pwd_nxt   = pwd_r;
        to_nxt    = to_r;
        we_nxt    = 1'b0;
        waddr_nxt = waddr_r;
        wdata_nxt = wdata_r;
        wclr_nxt  = 1'b0;
        pwr_nxt   = pwr_r;
        case (pwr_r)
            RSSE_RUN: begin
                if (act) begin
                    case (instr_op)
                        RSSE_OP_ROT_LEFT, RSSE_OP_ROT_RIGHT: begin
                            c_nxt = alu_c;
                            if (dest_sel == `RSSE_DEST_FILE) begin
                                we_nxt    = 1'b1;
                                waddr_nxt = file_addr;
                                wdata_nxt = alu_res;
                            end else begin
                                accum_nxt = alu_res;
                            end
                        end
                        RSSE_OP_SUB_LIT: begin
                            accum_nxt = alu_res;
                            c_nxt     = alu_c;
                            hb_nxt    = alu_hb;
                            z_nxt     = alu_z;
                        end
                        RSSE_OP_SLEEP: begin
                            pwd_nxt  = 1'b0;
                            to_nxt   = 1'b1;
                            wclr_nxt = 1'b1;
                            pwr_nxt  = RSSE_ASLEEP;
                        end
                        default: begin
                            pwr_nxt = RSSE_RUN;
                        end
                    endcase
                end
            end
            RSSE_ASLEEP: begin
                if (wake) begin
                    pwr_nxt = RSSE_RUN;
                end
            end
            default: begin
                pwr_nxt = RSSE_RUN;
            end
        endcase
    end

    // registers; power-on leaves the power-down and time-out flags high
    always_ff @(posedge mclk) begin
        if (rst) begin
            accum_r <= `RSSE_ACC_RST;
            c_r     <= 1'b0;
            hb_r    <= 1'b0;
            z_r     <= 1'b0;
            pwd_r   <= 1'b1;
            to_r    <= 1'b1;
            we_r    <= 1'b0;
            waddr_r <= '0;
            wdata_r <= '0;
            wclr_r  <= 1'b0;
            pwr_r   <= RSSE_RUN;
        end else begin
            accum_r <= accum_nxt;
            c_r     <= c_nxt;
            hb_r    <= hb_nxt;
            z_r     <= z_nxt;
            pwd_r   <= pwd_nxt;
            to_r    <= to_nxt;
            we_r    <= we_nxt;
            waddr_r <= waddr_nxt;
            wdata_r <= wdata_nxt;
            wclr_r  <= wclr_nxt;
            pwr_r   <= pwr_nxt;
        end
    end

    // outputs straight from flops
    assign accum            = accum_r;
    assign carry_flag       = c_r;
    assign half_borrow_flag = hb_r;
    assign zero_flag        = z_r;
    assign power_down_flag  = pwd_r;
    assign time_out_flag    = to_r;
    assign file_we          = we_r;
    assign file_waddr       = waddr_r;
    assign file_wdata       = wdata_r;
    assign wdt_clear        = wclr_r;
    assign osc_run          = (pwr_r == RSSE_RUN);
    assign exec_halted      = (pwr_r == RSSE_ASLEEP);

    // checks
    rot_left_a: assert property (@(posedge mclk) disable iff (rst)
        act && instr_op == RSSE_OP_ROT_LEFT |=> carry_flag == $past(file_rdata[`RSSE_MSB]))
        else $error("rotate left carry wrong");
    rot_left_dst_a: assert property (@(posedge mclk) disable iff (rst)
        act && instr_op == RSSE_OP_ROT_LEFT && !dest_sel
        |=> !file_we && accum == {$past(file_rdata[6:0]), $past(c_r)})
        else $error("rotate left to accumulator wrong");
    rot_right_a: assert property (@(posedge mclk) disable iff (rst)
        act && instr_op == RSSE_OP_ROT_RIGHT |=> carry_flag == $past(file_rdata[0]))
        else $error("rotate right carry wrong");
    rot_right_dst_a: assert property (@(posedge mclk) disable iff (rst)
        act && instr_op == RSSE_OP_ROT_RIGHT && dest_sel
        |=> file_we && file_wdata == {$past(c_r), $past(file_rdata[7:1])}
            && accum == $past(accum_r))
        else $error("rotate right to file wrong");
    sleep_flags_a: assert property (@(posedge mclk) disable iff (rst)
        act && instr_op == RSSE_OP_SLEEP |=> !power_down_flag && time_out_flag
            && carry_flag == $past(c_r) && zero_flag == $past(z_r))
        else $error("sleep flags wrong");
    sleep_wdt_a: assert property (@(posedge mclk) disable iff (rst)
        act && instr_op == RSSE_OP_SLEEP |=> wdt_clear ##1 !wdt_clear)
        else $error("watchdog clear pulse wrong");
    sleep_halt_a: assert property (@(posedge mclk) disable iff (rst)
        exec_halted && !wake |=> exec_halted && !osc_run && !file_we)
        else $error("woke without wake");
    sub_result_a: assert property (@(posedge mclk) disable iff (rst)
        act && instr_op == RSSE_OP_SUB_LIT |=> accum == $past(literal) - $past(accum_r))
        else $error("literal subtract result wrong");
    sub_carry_a: assert property (@(posedge mclk) disable iff (rst)
        act && instr_op == RSSE_OP_SUB_LIT |=> carry_flag == ($past(accum_r) <= $past(literal))
            && half_borrow_flag == ($past(accum_r[3:0]) <= $past(literal[3:0])))
        else $error("literal subtract borrow flags wrong");
    one_cycle_a: assert property (@(posedge mclk) disable iff (rst)
        act && instr_op == RSSE_OP_SUB_LIT ##1 act && instr_op == RSSE_OP_SUB_LIT
        |=> accum == $past(literal) - $past(accum_r))
        else $error("back to back subtract stalled");
    sub_zero_a: assert property (@(posedge mclk) disable iff (rst)
        act && instr_op == RSSE_OP_SUB_LIT |=> zero_flag == (accum == 8'h00))
        else $error("zero flag wrong");
    c_sleep: cover property (@(posedge mclk) disable iff (rst)
        act && instr_op == RSSE_OP_SLEEP ##[1:20] wake);
    c_sub_zero: cover property (@(posedge mclk) disable iff (rst)
        act && instr_op == RSSE_OP_SUB_LIT ##1 zero_flag);
    c_rot_file: cover property (@(posedge mclk) disable iff (rst) file_we);
    c_rot_acc: cover property (@(posedge mclk) disable iff (rst)
        act && instr_op == RSSE_OP_ROT_RIGHT && !dest_sel);
    c_sub_borrow: cover property (@(posedge mclk) disable iff (rst)
        act && instr_op == RSSE_OP_SUB_LIT ##1 !carry_flag);
    // the clear pulse must never appear without a sleep behind it
    clear_source_a: assert property (@(posedge mclk) disable iff (rst)
        wdt_clear |-> $past(act && instr_op == RSSE_OP_SLEEP))
        else $error("watchdog clear without sleep");
    rot_flags_a: assert property (@(posedge mclk) disable iff (rst)
        act && (instr_op == RSSE_OP_ROT_LEFT || instr_op == RSSE_OP_ROT_RIGHT)
        |=> half_borrow_flag == $past(hb_r) && zero_flag == $past(z_r))
        else $error("rotate touched other flags");
endmodule : rsse_exec

// [dv/tb.sv]
// self-checking bench for the rotate / sleep / literal-subtract execution block
`timescale 1ns/1ps
module tb;
    import rsse_pkg::*;
    logic       mclk = 1'b0;
    logic       rst = 1'b1;
    logic       instr_valid = 1'b0;
    rsse_op_t   instr_op = RSSE_OP_NONE;
    logic [6:0] file_addr = 7'h00;
    logic       dest_sel = 1'b0;
    logic [7:0] literal = 8'h00;
    logic [7:0] file_rdata = 8'h00;
    logic       wake = 1'b0;
    logic       file_we, wdt_clear, osc_run, exec_halted;
    logic [6:0] file_waddr;
    logic [7:0] file_wdata, accum;
    logic       carry_flag, half_borrow_flag, zero_flag, power_down_flag, time_out_flag;
    logic [7:0] m_acc = 8'h00;
    logic       m_c = 1'b0, m_hb = 1'b0, m_z = 1'b0;
    logic [31:0] rnd = 32'h2472;
    int         err_count = 0, check_count = 0, cyc = 0;
    rsse_exec i_rsse_exec (.mclk(mclk), .rst(rst), .instr_valid(instr_valid),
        .instr_op(instr_op), .file_addr(file_addr), .dest_sel(dest_sel), .literal(literal),
        .file_rdata(file_rdata), .wake(wake), .file_we(file_we), .file_waddr(file_waddr),
        .file_wdata(file_wdata), .accum(accum), .carry_flag(carry_flag),
        .half_borrow_flag(half_borrow_flag), .zero_flag(zero_flag),
        .power_down_flag(power_down_flag), .time_out_flag(time_out_flag),
        .wdt_clear(wdt_clear), .osc_run(osc_run), .exec_halted(exec_halted));
    // 8 ns clock
    initial begin
        forever #4 mclk = ~mclk;
    end
    // a hang would otherwise never reach the verdict
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            close_out();
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction : xs
    // expected {carry, result} of a rotate through the carry
    function automatic logic [8:0] rot_exp(input logic left, input logic [7:0] v,
                                           input logic c);
        if (left) return {v, c};
        return {v[0], c, v[7:1]};
    endfunction : rot_exp
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk8
    task automatic chk1(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk1
    // present one instruction, let its edge pass, compare against the bench model
    task automatic run_op(input rsse_op_t op, input logic [6:0] a, input logic d,
                          input logic [7:0] k, input logic [7:0] fd);
        logic [7:0] r;
        logic       we;
        instr_valid = 1'b1;
        instr_op = op;
        file_addr = a;
        dest_sel = d;
        literal = k;
        file_rdata = fd;
        we = 1'b0;
        r = m_acc;
        if (op == RSSE_OP_ROT_LEFT || op == RSSE_OP_ROT_RIGHT) begin
            {m_c, r} = rot_exp(op == RSSE_OP_ROT_LEFT, fd, m_c);
        end else if (op == RSSE_OP_SUB_LIT) begin
            r = k - m_acc;
            m_c = (m_acc <= k);
            m_hb = (m_acc[3:0] <= k[3:0]);
            m_z = (r == 8'h00);
            m_acc = r;
        end
        if (op == RSSE_OP_ROT_LEFT || op == RSSE_OP_ROT_RIGHT) begin
            if (d) we = 1'b1;
            else m_acc = r;
        end
        @(posedge mclk);
        #1;
        chk8(accum, m_acc);
        chk1(carry_flag, m_c);
        chk1(half_borrow_flag, m_hb);
        chk1(zero_flag, m_z);
        chk1(file_we, we);
        chk1(exec_halted, 1'b0);
        if (we) begin
            chk8(file_wdata, r);
            chk8({1'b0, file_waddr}, {1'b0, a});
        end
    endtask : run_op
    // random back-to-back traffic, no idle cycles between instructions
    task automatic rand_run(input int n);
        rsse_op_t op;
        for (int i = 0; i < n; i++) begin
            rnd = xs(rnd);
            case (rnd[1:0])
                2'h0: op = RSSE_OP_ROT_LEFT;
                2'h1: op = RSSE_OP_ROT_RIGHT;
                2'h2: op = RSSE_OP_SUB_LIT;
                default: op = RSSE_OP_NONE;
            endcase
            run_op(op, rnd[8:2], rnd[9], rnd[17:10], rnd[25:18]);
        end
    endtask : rand_run
    // sleep, try an instruction while halted, then wake
    task automatic sleep_seq();
        run_op(RSSE_OP_NONE, 7'h00, 1'b0, 8'h00, 8'h00);
        instr_op = RSSE_OP_SLEEP;
        @(posedge mclk);
        #1;
        chk1(power_down_flag, 1'b0);
        chk1(time_out_flag, 1'b1);
        chk1(wdt_clear, 1'b1);
        chk1(exec_halted, 1'b1);
        chk1(osc_run, 1'b0);
        chk1(carry_flag, m_c);
        chk1(zero_flag, m_z);
        chk1(half_borrow_flag, m_hb);
        instr_op = RSSE_OP_SUB_LIT;
        literal = 8'h5a;
        @(posedge mclk);
        #1;
        chk1(wdt_clear, 1'b0);
        chk8(accum, m_acc);
        chk1(exec_halted, 1'b1);
        wake = 1'b1;
        @(posedge mclk);
        #1;
        wake = 1'b0;
        instr_valid = 1'b0;
        chk1(osc_run, 1'b1);
        chk1(power_down_flag, 1'b0);
        chk8(accum, m_acc);
        // an operation without instr_valid must leave the accumulator alone
        @(posedge mclk);
        #1;
        chk8(accum, m_acc);
    endtask : sleep_seq
    task automatic close_out();
        $display("errors=%0d checks=%0d", err_count, check_count);
        if (err_count == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out
    // main sequence: reset, corner cases, random traffic, sleep and wake
    initial begin
        repeat (3) @(posedge mclk);
        #1;
        rst = 1'b0;
        chk1(power_down_flag, 1'b1);
        chk1(osc_run, 1'b1);
        chk1(wdt_clear, 1'b0);
        run_op(RSSE_OP_ROT_LEFT, 7'h00, 1'b0, 8'h00, 8'he6);
        run_op(RSSE_OP_ROT_RIGHT, 7'h7f, 1'b1, 8'h00, 8'h01);
        run_op(RSSE_OP_ROT_LEFT, 7'h7f, 1'b1, 8'h00, 8'h80);
        run_op(RSSE_OP_ROT_RIGHT, 7'h40, 1'b0, 8'h00, 8'h00);
        run_op(RSSE_OP_SUB_LIT, 7'h00, 1'b0, 8'h00, 8'h00);
        run_op(RSSE_OP_SUB_LIT, 7'h00, 1'b1, 8'h10, 8'h00);
        run_op(RSSE_OP_SUB_LIT, 7'h00, 1'b0, 8'h0f, 8'h00);
        run_op(RSSE_OP_SUB_LIT, 7'h00, 1'b0, 8'h00, 8'h00);
        run_op(RSSE_OP_SUB_LIT, 7'h00, 1'b0, 8'hff, 8'h00);
        rand_run(300);
        sleep_seq();
        rand_run(200);
        close_out();
    end
endmodule : tb
